// [logic/cpq_pkg.sv]
// Constants and types for the PWM and phase count controller
package cpq_pkg;

  // ----------------------------------------------------------------
  // Data and select widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int SEL_W = 4;

  // ----------------------------------------------------------------
  // Device register selects on the device write port
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_START = 4'h0;
  localparam logic [3:0] SEL_CTRL3 = 4'h1;
  localparam logic [3:0] SEL_CTRL4 = 4'h2;
  localparam logic [3:0] SEL_MODE_B = 4'h3;
  localparam logic [3:0] SEL_CNT3 = 4'h4;
  localparam logic [3:0] SEL_CNT4 = 4'h5;
  localparam logic [3:0] SEL_LIMIT = 4'h6;
  localparam logic [3:0] SEL_TP1 = 4'h7;
  localparam logic [3:0] SEL_BUF1 = 4'ha;
  localparam logic [3:0] SEL_MODE = 4'hd;

  // ----------------------------------------------------------------
  // Device field positions and values
  // ----------------------------------------------------------------
  localparam int START_CH2_BIT = 2;
  localparam int START_CH3_BIT = 3;
  localparam int START_CH4_BIT = 4;
  localparam int PRESCALE_LSB = 0;
  localparam int EDGE_LSB = 3;
  localparam int CLEAR_LSB = 5;
  localparam logic [1:0] CLEAR_NONE = 2'h0;
  localparam int COMB_LSB = 0;
  localparam logic [1:0] COMB_COMPLEMENTARY = 2'h3;
  localparam int PHASE_SEL_BIT = 6;
  localparam int DIR_COND_BIT = 5;
  localparam logic [15:0] CNT4_INIT = 16'h0000;
  localparam logic [16:0] LIMIT_BIAS = 17'h00002;

  // ----------------------------------------------------------------
  // Avalon register word offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] AV_CTRL = 4'h0;
  localparam logic [3:0] AV_STATUS = 4'h1;
  localparam logic [3:0] AV_OFFSET = 4'h2;
  localparam logic [3:0] AV_HALF = 4'h3;
  localparam logic [3:0] AV_TURN1 = 4'h4;
  localparam logic [3:0] AV_QUAD = 4'h7;
  localparam logic [3:0] AV_REFUSED = 4'h8;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Quadrature timing, in device clock cycles (tenths)
  // ----------------------------------------------------------------
  localparam int QUAD_OVERLAP_TENTHS = 15;
  localparam int QUAD_WIDTH_TENTHS = 25;
  localparam int QUAD_STEP_A = (QUAD_OVERLAP_TENTHS + 9) / 10;
  localparam int QUAD_STEP_B = (QUAD_WIDTH_TENTHS + 19) / 20;
  localparam int QUAD_STEP_CYC = (QUAD_STEP_A > QUAD_STEP_B) ? QUAD_STEP_A : QUAD_STEP_B;

  typedef enum logic [4:0] {
    ST_IDLE, ST_HALT, ST_CTRL3, ST_CTRL4, ST_MODE_B, ST_CNT4, ST_CNT3,
    ST_LIMIT, ST_TP, ST_GO, ST_RUN, ST_UPD, ST_PH_MODE, ST_PH_GO, ST_STOP
  } cpq_state_type;

endpackage

// [logic/cpq_sync2.sv]
// Two-flop synchroniser for device event pins
`timescale 1ns/1ps
module cpq_sync2 #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_ff <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // cpq_sync2

// [logic/cpq_quad_gen.sv]
// Quadrature pair generator for the phase counting input pins
`timescale 1ns/1ps
module cpq_quad_gen (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic dir_down,
  input wire logic [14:0] steps,
  output logic quad_a,
  output logic quad_b,
  output logic busy
);
  import cpq_pkg::*;

  localparam logic [7:0] STEP_LAST = 8'(QUAD_STEP_CYC - 1);

  logic [1:0] phase_ff;
  logic [14:0] left_ff;
  logic [7:0] tick_ff;
  logic down_ff;
  logic [1:0] nxt_phase;

  // Gray walk 00,01,11,10 counts up; reverse counts down
  assign nxt_phase = down_ff ? phase_ff - 2'h1 : phase_ff + 2'h1;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      phase_ff <= 2'h0;
      left_ff <= 15'h0000;
      tick_ff <= 8'h00;
      down_ff <= 1'b0;
      busy <= 1'b0;
      quad_a <= 1'b0;
      quad_b <= 1'b0;
    end
    else if (!busy)
    begin
      if (start && steps != 15'h0000)
      begin
        busy <= 1'b1;
        left_ff <= steps;
        down_ff <= dir_down;
        tick_ff <= 8'h00;
      end
    end
    else if (tick_ff != STEP_LAST)
    begin
      // Each level holds at least the overlap and half the width
      tick_ff <= tick_ff + 8'h01;
    end
    else
    begin
      tick_ff <= 8'h00;
      phase_ff <= nxt_phase;
      quad_a <= nxt_phase[1];
      quad_b <= nxt_phase[1] ^ nxt_phase[0];
      left_ff <= left_ff - 15'h0001;
      busy <= (left_ff != 15'h0001);
    end
  end
endmodule // cpq_quad_gen

// [logic/cpq_ctrl.sv]
// Host controller that programs complementary PWM and phase counting
//
// How it works
// - Load counter four zero, three the offset
// - Limit is half cycle plus offset minus two
// - Halt both counters, configure, then start both
// - Same clock both channels, no clear source
// - Never load both counters with equal values
// - Initial turning points not below the offset
// - Values below offset only after first match
// - Change turning points through buffers only
// - No crossing of top window at upturn
// - No crossing of bottom window at downturn
// - Leave and rejoin range in one direction
// - Write buffers only after match or underflow
// - Select phase count, flag condition, then start
// - Quadrature keeps overlap and width minimums
`timescale 1ns/1ps
module cpq_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [cpq_pkg::SEL_W-1:0] dev_sel,
  output logic [cpq_pkg::DATA_W-1:0] dev_wdata,
  output logic dev_wr,
  input wire logic dev_ch3_match,
  input wire logic dev_ch4_underflow,
  output logic quad_input_a,
  output logic quad_input_b
);
  import cpq_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cpq_state_type state_ff;
  logic [15:0] offset_ff;
  logic [15:0] half_ff;
  logic [15:0] limit_ff;
  logic [15:0] tp_ff [3];
  logic [15:0] gr_ff [3];
  logic [2:0] pend_ff;
  logic [2:0] odir_ff;
  logic [2:0] clk_sel_ff;
  logic [1:0] edge_sel_ff;
  logic dir_cond_ff;
  logic [2:0] start_bits_ff;
  logic [1:0] idx_ff;
  logic dir_down_ff;
  logic first_match_ff;
  logic cfg_err_ff;
  logic ph_run_ff;
  logic [15:0] refused_ff;
  logic [1:0] evt_prev_ff;
  logic [1:0] evt_sync;
  logic match_evt;
  logic under_evt;
  logic acc_ok;
  logic wr_acc;
  logic go_pwm;
  logic go_phase;
  logic go_stop;
  logic quad_busy;
  logic quad_go;
  logic [31:0] rd_mux;
  logic [16:0] limit_sum;
  logic cfg_bad;
  logic upd_allowed;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic upd_ok(input logic [15:0] cur, input logic [15:0] nv,
                                  input logic [15:0] off, input logic [15:0] lim,
                                  input logic down, input logic first, input logic odir);
    logic [15:0] top_lo;
    logic ci;
    logic ni;
    logic ok;
    top_lo = lim - off + 16'h0001;
    if (down)
    begin
      // Next copy happens at underflow
      ci = cur < off;
      ni = nv < off;
    end
    else
    begin
      // Next copy happens at the limit match
      ci = (cur >= top_lo) && (cur <= lim);
      ni = (nv >= top_lo) && (nv <= lim);
    end
    ok = (ci == ni);
    if (!first && nv < off)
      ok = 1'b0;
    if (cur > lim && nv <= lim && odir != down)
      ok = 1'b0;
    return ok;
  endfunction

  function automatic logic [15:0] start_word(input logic [2:0] bits);
    logic [15:0] w;
    w = RST_WORD;
    w[START_CH2_BIT] = bits[0];
    w[START_CH3_BIT] = bits[1];
    w[START_CH4_BIT] = bits[2];
    return w;
  endfunction

  function automatic logic [15:0] ctrl_word(input logic [2:0] cs, input logic [1:0] es);
    logic [15:0] w;
    w = RST_WORD;
    w[PRESCALE_LSB +: 3] = cs;
    w[EDGE_LSB +: 2] = es;
    w[CLEAR_LSB +: 2] = CLEAR_NONE;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, answer at the second edge
  // ----------------------------------------------------------------
  assign acc_ok = (avs_read || avs_write) && !avs_waitrequest;
  assign wr_acc = avs_write && !avs_waitrequest;
  assign go_pwm = wr_acc && avs_address == AV_CTRL && avs_writedata[0];
  assign go_phase = wr_acc && avs_address == AV_CTRL && avs_writedata[1];
  assign go_stop = wr_acc && avs_address == AV_CTRL && avs_writedata[2];
  assign quad_go = wr_acc && avs_address == AV_QUAD;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      avs_waitrequest <= 1'b1;
    else if (acc_ok)
      avs_waitrequest <= 1'b1;
    else if (avs_read || avs_write)
      avs_waitrequest <= 1'b0;
  end

  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (avs_address)
      AV_CTRL: rd_mux = {22'h000000, dir_cond_ff, edge_sel_ff, clk_sel_ff, 4'h0};
      AV_STATUS: rd_mux = {24'h000000, pend_ff, ph_run_ff, cfg_err_ff, first_match_ff,
                           state_ff == ST_RUN || state_ff == ST_UPD, state_ff != ST_IDLE
                           && state_ff != ST_RUN && state_ff != ST_UPD};
      AV_OFFSET: rd_mux = {16'h0000, offset_ff};
      AV_HALF: rd_mux = {16'h0000, half_ff};
      4'h4, 4'h5, 4'h6: rd_mux = {16'h0000, tp_ff[avs_address[1:0]]};
      AV_QUAD: rd_mux = {31'h00000000, quad_busy};
      AV_REFUSED: rd_mux = {16'h0000, refused_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      avs_readdata <= 32'h00000000;
    else if ((avs_read || avs_write) && avs_waitrequest)
      avs_readdata <= avs_read ? rd_mux : 32'h00000000;
  end

  // ----------------------------------------------------------------
  // Software configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      offset_ff <= RST_WORD;
      half_ff <= RST_WORD;
      clk_sel_ff <= 3'h0;
      edge_sel_ff <= 2'h0;
      dir_cond_ff <= 1'b0;
      for (int i = 0; i < 3; i++)
        tp_ff[i] <= RST_WORD;
    end
    else if (wr_acc)
    begin
      if (avs_address == AV_CTRL)
      begin
        clk_sel_ff <= avs_writedata[6:4];
        edge_sel_ff <= avs_writedata[8:7];
        dir_cond_ff <= avs_writedata[9];
      end
      if (avs_address == AV_OFFSET && state_ff == ST_IDLE)
        offset_ff <= avs_writedata[15:0];
      if (avs_address == AV_HALF && state_ff == ST_IDLE)
        half_ff <= avs_writedata[15:0];
      if (avs_address >= AV_TURN1 && avs_address <= 4'h6)
        tp_ff[avs_address[1:0]] <= avs_writedata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Device event pins
  // ----------------------------------------------------------------
  cpq_sync2 #(.W(2)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({dev_ch4_underflow, dev_ch3_match}),
    .sync_out(evt_sync)
  );

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      evt_prev_ff <= 2'h0;
    else
      evt_prev_ff <= evt_sync;
  end

  assign match_evt = evt_sync[0] && !evt_prev_ff[0];
  assign under_evt = evt_sync[1] && !evt_prev_ff[1];

  // Counters turn down after the limit match, up after underflow
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dir_down_ff <= 1'b0;
      first_match_ff <= 1'b0;
    end
    else if (state_ff == ST_GO)
    begin
      dir_down_ff <= 1'b0;
      first_match_ff <= 1'b0;
    end
    else if (match_evt)
    begin
      dir_down_ff <= 1'b1;
      first_match_ff <= 1'b1;
    end
    else if (under_evt)
      dir_down_ff <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Pending turning point updates
  // ----------------------------------------------------------------
  assign upd_allowed = upd_ok(gr_ff[idx_ff], tp_ff[idx_ff], offset_ff, limit_ff,
                              dir_down_ff, first_match_ff, odir_ff[idx_ff]);

  // A fresh write in the send cycle stays pending
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pend_ff <= 3'h0;
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (wr_acc && avs_address == 4'(AV_TURN1 + 4'(i)) && state_ff != ST_IDLE)
          pend_ff[i] <= 1'b1;
        else if (state_ff == ST_UPD && idx_ff == 2'(i) && upd_allowed)
          pend_ff[i] <= 1'b0;
        else if (state_ff == ST_IDLE)
          pend_ff[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      odir_ff <= 3'h0;
      refused_ff <= RST_WORD;
      for (int i = 0; i < 3; i++)
        gr_ff[i] <= RST_WORD;
    end
    else if (state_ff == ST_TP)
      gr_ff[idx_ff] <= tp_ff[idx_ff];
    else if (state_ff == ST_UPD && pend_ff[idx_ff])
    begin
      if (upd_allowed)
      begin
        gr_ff[idx_ff] <= tp_ff[idx_ff];
        if (tp_ff[idx_ff] > limit_ff)
          odir_ff[idx_ff] <= dir_down_ff;
      end
      else
        refused_ff <= refused_ff + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and device write port
  // ----------------------------------------------------------------
  assign limit_sum = {1'b0, half_ff} + {1'b0, offset_ff} - LIMIT_BIAS;
  assign cfg_bad = (offset_ff == CNT4_INIT) || limit_sum[16]
                   || tp_ff[0] < offset_ff || tp_ff[1] < offset_ff
                   || tp_ff[2] < offset_ff;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff <= ST_IDLE;
      idx_ff <= 2'h0;
      dev_wr <= 1'b0;
      dev_sel <= SEL_START;
      dev_wdata <= RST_WORD;
      start_bits_ff <= 3'h0;
      limit_ff <= RST_WORD;
      cfg_err_ff <= 1'b0;
      ph_run_ff <= 1'b0;
    end
    else
    begin
      dev_wr <= 1'b0;
      unique case (state_ff)
        ST_IDLE:
          if (go_pwm && cfg_bad)
            cfg_err_ff <= 1'b1;
          else if (go_pwm)
          begin
            cfg_err_ff <= 1'b0;
            limit_ff <= limit_sum[15:0];
            state_ff <= ST_HALT;
          end
          else if (go_phase && !ph_run_ff)
            state_ff <= ST_PH_MODE;
        ST_HALT:
        begin
          start_bits_ff <= {2'b00, start_bits_ff[0]};
          dev_sel <= SEL_START;
          dev_wdata <= start_word({2'b00, start_bits_ff[0]});
          dev_wr <= 1'b1;
          state_ff <= ST_CTRL3;
        end
        ST_CTRL3, ST_CTRL4:
        begin
          dev_sel <= (state_ff == ST_CTRL3) ? SEL_CTRL3 : SEL_CTRL4;
          dev_wdata <= ctrl_word(clk_sel_ff, edge_sel_ff);
          dev_wr <= 1'b1;
          state_ff <= (state_ff == ST_CTRL3) ? ST_CTRL4 : ST_MODE_B;
        end
        ST_MODE_B:
        begin
          // Output pins follow the mode once this lands
          dev_sel <= SEL_MODE_B;
          dev_wdata <= {14'h0000, COMB_COMPLEMENTARY};
          dev_wr <= 1'b1;
          state_ff <= ST_CNT4;
        end
        ST_CNT4:
        begin
          dev_sel <= SEL_CNT4;
          dev_wdata <= CNT4_INIT;
          dev_wr <= 1'b1;
          state_ff <= ST_CNT3;
        end
        ST_CNT3:
        begin
          dev_sel <= SEL_CNT3;
          dev_wdata <= offset_ff;
          dev_wr <= 1'b1;
          state_ff <= ST_LIMIT;
        end
        ST_LIMIT:
        begin
          dev_sel <= SEL_LIMIT;
          dev_wdata <= limit_ff;
          dev_wr <= 1'b1;
          idx_ff <= 2'h0;
          state_ff <= ST_TP;
        end
        ST_TP:
        begin
          // Direct writes only while halted; one per output pair
          dev_sel <= SEL_TP1 + 4'(idx_ff);
          dev_wdata <= tp_ff[idx_ff];
          dev_wr <= 1'b1;
          idx_ff <= idx_ff + 2'h1;
          if (idx_ff == 2'h2)
            state_ff <= ST_GO;
        end
        ST_GO:
        begin
          start_bits_ff <= {2'b11, start_bits_ff[0]};
          dev_sel <= SEL_START;
          dev_wdata <= start_word({2'b11, start_bits_ff[0]});
          dev_wr <= 1'b1;
          state_ff <= ST_RUN;
        end
        ST_RUN:
          if (go_stop)
            state_ff <= ST_STOP;
          else if ((match_evt || under_evt) && pend_ff != 3'h0)
          begin
            idx_ff <= 2'h0;
            state_ff <= ST_UPD;
          end
          else if (go_phase && !ph_run_ff)
            state_ff <= ST_PH_MODE;
        ST_UPD:
        begin
          if (pend_ff[idx_ff] && upd_allowed)
          begin
            // Only the buffer is touched while running
            dev_sel <= SEL_BUF1 + 4'(idx_ff);
            dev_wdata <= tp_ff[idx_ff];
            dev_wr <= 1'b1;
          end
          idx_ff <= idx_ff + 2'h1;
          if (idx_ff == 2'h2)
            state_ff <= ST_RUN;
        end
        ST_PH_MODE:
        begin
          dev_sel <= SEL_MODE;
          dev_wdata <= (16'h0001 << PHASE_SEL_BIT)
                       | (16'(dir_cond_ff) << DIR_COND_BIT);
          dev_wr <= 1'b1;
          state_ff <= ST_PH_GO;
        end
        ST_PH_GO:
        begin
          start_bits_ff <= {start_bits_ff[2:1], 1'b1};
          dev_sel <= SEL_START;
          dev_wdata <= start_word({start_bits_ff[2:1], 1'b1});
          dev_wr <= 1'b1;
          ph_run_ff <= 1'b1;
          state_ff <= (start_bits_ff[1]) ? ST_RUN : ST_IDLE;
        end
        ST_STOP:
        begin
          start_bits_ff <= 3'h0;
          dev_sel <= SEL_START;
          dev_wdata <= RST_WORD;
          dev_wr <= 1'b1;
          ph_run_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Encoder stand-in on the channel two clock pins
  // ----------------------------------------------------------------
  cpq_quad_gen u_quad (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(quad_go),
    .dir_down(avs_writedata[15]),
    .steps(avs_writedata[14:0]),
    .quad_a(quad_input_a),
    .quad_b(quad_input_b),
    .busy(quad_busy)
  );

endmodule // cpq_ctrl

// [bench/cpq_ctrl_properties.sv]
// Port checker for the PWM and phase count controller
`timescale 1ns/1ps
module cpq_ctrl_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [cpq_pkg::SEL_W-1:0] dev_sel,
  input wire logic [cpq_pkg::DATA_W-1:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic quad_input_a,
  input wire logic quad_input_b
);
  import cpq_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic req;
  assign req = avs_read | avs_write;
  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  a_wait_after_req: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait not released");
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  a_idle_wait_high: assert property (!req |=> avs_waitrequest)
    else $error("wait low when idle");
  // ----------------------------------------------------------------
  // Device programming order
  // ----------------------------------------------------------------
  a_halt_before_cfg: assert property (dev_wr && dev_sel == SEL_CTRL3 |->
    $past(dev_wr) && $past(dev_sel) == SEL_START) else $error("config without halt");
  a_same_clock: assert property (dev_wr && dev_sel == SEL_CTRL3 |->
    dev_wdata[CLEAR_LSB +: 2] == CLEAR_NONE ##1 dev_wr && dev_sel == SEL_CTRL4
    && dev_wdata == $past(dev_wdata)) else $error("channel setup differs");
  a_comb_mode: assert property (dev_wr && dev_sel == SEL_MODE_B |->
    dev_wdata[COMB_LSB +: 2] == COMB_COMPLEMENTARY) else $error("wrong combination mode");
  a_cnt_load: assert property (dev_wr && dev_sel == SEL_CNT4 |->
    dev_wdata == CNT4_INIT ##1 dev_wr && dev_sel == SEL_CNT3 && dev_wdata != CNT4_INIT)
    else $error("bad counter load");
  a_go_after_tp: assert property (dev_wr && dev_sel == SEL_LIMIT |=>
    dev_wr && dev_sel == SEL_TP1 ##1 dev_wr [*2] ##1 dev_wr && dev_sel == SEL_START
    && dev_wdata[START_CH3_BIT] && dev_wdata[START_CH4_BIT]) else $error("bad start order");
  a_phase_go: assert property (dev_wr && dev_sel == SEL_MODE |->
    dev_wdata[PHASE_SEL_BIT] ##[1:4] dev_wr && dev_sel == SEL_START
    && dev_wdata[START_CH2_BIT]) else $error("bad phase start");
  // ----------------------------------------------------------------
  // Quadrature pins
  // ----------------------------------------------------------------
  a_quad_one_bit: assert property (!($changed(quad_input_a) && $changed(quad_input_b)))
    else $error("two quad pins moved");
  a_quad_hold: assert property ($changed({quad_input_a, quad_input_b}) |=>
    $stable({quad_input_a, quad_input_b})) else $error("quad step too short");
  c_pwm_go: cover property (dev_wr && dev_sel == SEL_LIMIT);
  c_buf_copy: cover property (dev_wr && dev_sel == SEL_BUF1);
  c_phase_go: cover property (dev_wr && dev_sel == SEL_MODE);
endmodule // cpq_ctrl_properties

bind cpq_ctrl cpq_ctrl_properties i_cpq_ctrl_properties (.clk(clk), .sys_rst(sys_rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .dev_sel(dev_sel), .dev_wdata(dev_wdata), .dev_wr(dev_wr),
  .quad_input_a(quad_input_a), .quad_input_b(quad_input_b));

// [bench/cpq_dev_model.sv]
// Behavioural model of the timer device
`timescale 1ns/1ps
module cpq_dev_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [cpq_pkg::SEL_W-1:0] dev_sel,
  input wire logic [cpq_pkg::DATA_W-1:0] dev_wdata,
  input wire logic dev_wr,
  input wire logic quad_input_a,
  input wire logic quad_input_b,
  output logic dev_ch3_match,
  output logic dev_ch4_underflow
);
  import cpq_pkg::*;
  logic [15:0] regs_ff [16];
  logic [15:0] ch2_counter_ff;
  logic [1:0] quad_prev_ff;
  logic phase_on;
  initial dev_ch3_match = 1'b0;
  initial dev_ch4_underflow = 1'b0;
  // Any stored value accepted, above limit too
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      for (int i = 0; i < 16; i++) regs_ff[i] <= 16'h0000;
    else if (dev_wr)
      regs_ff[dev_sel] <= dev_wdata;
  // Only channel 2 counts, and only once selected and started
  assign phase_on = regs_ff[SEL_MODE][PHASE_SEL_BIT] & regs_ff[SEL_START][START_CH2_BIT];
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      quad_prev_ff <= 2'h0;
      ch2_counter_ff <= 16'h0000;
    end
    else
    begin
      quad_prev_ff <= {quad_input_a, quad_input_b};
      if (phase_on)
        case ({quad_prev_ff, quad_input_a, quad_input_b})
          4'h1, 4'h7, 4'he, 4'h8: ch2_counter_ff <= ch2_counter_ff + 16'h0001;
          4'h2, 4'hb, 4'hd, 4'h4: ch2_counter_ff <= ch2_counter_ff - 16'h0001;
          default: ;
        endcase
    end
  // Reversal event, three cycles wide so the synchroniser sees it
  task fire(input bit uf);
    @(posedge clk);
    dev_ch3_match <= !uf;
    dev_ch4_underflow <= uf;
    repeat (3) @(posedge clk);
    dev_ch3_match <= 1'b0;
    dev_ch4_underflow <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
endmodule // cpq_dev_model

// [bench/cpq_ctrl_tb.sv]
// Self-checking bench for the PWM and phase count controller
`timescale 1ns/1ps
module cpq_ctrl_tb;
  import cpq_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, dev_wr, dev_ch3_match, dev_ch4_underflow, qa, qb;
  logic [SEL_W-1:0] dev_sel;
  logic [DATA_W-1:0] dev_wdata;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  cpq_ctrl i_cpq_ctrl (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dev_sel(dev_sel),
    .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_ch3_match(dev_ch3_match),
    .dev_ch4_underflow(dev_ch4_underflow), .quad_input_a(qa), .quad_input_b(qb));
  cpq_dev_model i_cpq_dev_model (.clk(clk), .sys_rst(sys_rst), .dev_sel(dev_sel),
    .dev_wdata(dev_wdata), .dev_wr(dev_wr), .quad_input_a(qa), .quad_input_b(qb),
    .dev_ch3_match(dev_ch3_match), .dev_ch4_underflow(dev_ch4_underflow));
  task test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      test_done();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // One Avalon access, held until waitrequest low
  task av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task poll(input logic [3:0] a, input int b, input logic v);
    for (int i = 0; i < 60; i++)
    begin
      av(0, a, 0);
      if (rd[b] === v) break;
    end
    chk("poll", v, rd[b]);
  endtask
  function automatic logic [31:0] dreg(input int s);
    return {16'h0, i_cpq_dev_model.regs_ff[s]};
  endfunction
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    av(0, AV_STATUS, 0); chk("status", 0, rd);
    av(1, 4'hf, 32'h1234); av(0, 4'hf, 0); chk("unmapped", 0, rd);
    // Offset 4, half 100, so limit 102; first turn point under offset
    av(1, AV_OFFSET, 4); av(1, AV_HALF, 100); av(1, AV_TURN1, 2);
    av(1, AV_TURN1 + 4'h1, 30); av(1, AV_TURN1 + 4'h2, 200);
    av(1, AV_CTRL, 32'h1 | (5 << 4) | (2 << 7));
    poll(AV_STATUS, 3, 1);
    chk("cnt3", 0, dreg(SEL_CNT3));
    av(1, AV_TURN1, 10); av(1, AV_CTRL, 32'h1 | (5 << 4) | (2 << 7));
    poll(AV_STATUS, 1, 1);
    chk("cnt4", 0, dreg(SEL_CNT4));
    chk("cnt3", 4, dreg(SEL_CNT3));
    chk("limit", 102, dreg(SEL_LIMIT));
    chk("tp1", 10, dreg(SEL_TP1));
    chk("tp2", 30, dreg(SEL_TP1 + 1));
    chk("tp3", 200, dreg(SEL_TP1 + 2));
    chk("ctrl3", (5 << PRESCALE_LSB) | (2 << EDGE_LSB), dreg(SEL_CTRL3));
    chk("ctrl4", (5 << PRESCALE_LSB) | (2 << EDGE_LSB), dreg(SEL_CTRL4));
    chk("comb", COMB_COMPLEMENTARY, dreg(SEL_MODE_B) & 3);
    chk("go", 3, dreg(SEL_START) >> START_CH3_BIT & 3);
    // Buffered change at a match, then refusals at both turns
    av(1, AV_TURN1, 20); i_cpq_dev_model.fire(0);
    chk("buf1", 20, dreg(SEL_BUF1));
    av(1, AV_TURN1, 2); i_cpq_dev_model.fire(0);
    av(0, AV_REFUSED, 0); chk("refused", 1, rd);
    chk("buf1", 20, dreg(SEL_BUF1));
    av(1, AV_TURN1 + 4'h1, 102); i_cpq_dev_model.fire(1);
    av(0, AV_REFUSED, 0); chk("refused", 2, rd);
    chk("buf2", 0, dreg(SEL_BUF1 + 1));
    av(1, AV_CTRL, 32'h4); poll(AV_STATUS, 1, 0);
    chk("stop", 0, dreg(SEL_START) >> START_CH3_BIT & 3);
    // Phase counting, second request while busy is dropped
    av(1, AV_CTRL, 32'h2 | (1 << 9)); poll(AV_STATUS, 4, 1);
    chk("mode", 3, dreg(SEL_MODE) >> DIR_COND_BIT & 3);
    chk("ch2go", 1, dreg(SEL_START) >> START_CH2_BIT & 1);
    av(1, AV_QUAD, 6); av(1, AV_QUAD, 6); poll(AV_QUAD, 0, 0);
    chk("ch2up", 6, i_cpq_dev_model.ch2_counter_ff);
    av(1, AV_QUAD, 32'h8004); poll(AV_QUAD, 0, 0);
    chk("ch2dn", 2, i_cpq_dev_model.ch2_counter_ff);
    test_done();
  end
endmodule // cpq_ctrl_tb
